//--- verilog/cmpr_ctrl.sv
// Control registers and edge logic for the second analog comparator.
// Assumes the core drives a one-cycle special-function read or write strobe
// and that the comparator output arrives asynchronously from the analog macro.
//
// Summary of operation
// - Falling comparator edge sets the falling flag while the enable bit is one; it holds until software clears.
// - Positive hysteresis code in control bits 3-2 selects off, 5, 10, 20 mV.
// - Negative hysteresis code in control bits 1-0 selects off, 5, 10, 20 mV.
// - Input-select bits 6-4 choose the negative input pin, codes 0 to 4.
// - Input-select bits 2-0 choose the positive input pin, codes 0 to 4.
// - Pin mapping depends on the package variant, chosen at build time.
// - Input-select bits 7 and 3 read zero and ignore writes.
// - Rising interrupt request allowed only while mode bit 5 is one.
// - Falling interrupt request allowed only while mode bit 4 is one.
// - Mode bits 1-0 drive response time; reset selects mode 2.
// - Mode bits 7 and 6 read zero and ignore writes.
// - Rising comparator edge sets the rising flag while the enable bit is one; it holds until software clears.
// - Read-only output bit shows one when positive input exceeds negative.
// - Comparator is powered only while the enable bit is one.
`include "cmpr_cfg.svh"
`default_nettype none

module cmpr_ctrl #(
    parameter bit PACKAGE_48PIN = 1'b0
) (
    input wire logic CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic [7:0] SFR_ADDR_IN,
    input wire logic SFR_WR_IN,
    input wire logic SFR_RD_IN,
    input wire logic [7:0] SFR_WDATA_IN,
    output logic [7:0] SFR_RDATA_OUT,
    input wire logic CMP_RAW_IN,
    output logic CMP_ENABLE_OUT,
    output cmpr_pkg::cmpr_hyst_e POS_HYST_OUT,
    output cmpr_pkg::cmpr_hyst_e NEG_HYST_OUT,
    output logic [7:0] POS_PIN_OUT,
    output logic [7:0] NEG_PIN_OUT,
    output cmpr_pkg::cmpr_resp_e RESP_MODE_OUT,
    output logic RISE_IRQ_OUT,
    output logic FALL_IRQ_OUT
);

    // Pin codes as {port, bit}; entries 0 to 4 per package variant
    localparam logic [7:0] POS_MAP_32 [5] = '{8'h12, 8'h16, 8'h22, 8'h26, 8'h04};
    localparam logic [7:0] POS_MAP_48 [5] = '{8'h22, 8'h30, 8'h37, 8'h45, 8'h11};
    localparam logic [7:0] NEG_MAP_32 [5] = '{8'h13, 8'h17, 8'h23, 8'h27, 8'h05};
    localparam logic [7:0] NEG_MAP_48 [5] = '{8'h23, 8'h31, 8'h40, 8'h46, 8'h12};

    logic comparator_enable_bit_q;
    logic rising_edge_flag_q;
    logic rising_edge_flag_d;
    logic falling_edge_flag_q;
    logic falling_edge_flag_d;
    logic [1:0] positive_hysteresis_sel_q;
    logic [1:0] negative_hysteresis_sel_q;
    logic [2:0] negative_input_sel_q;
    logic [2:0] positive_input_sel_q;
    logic rising_edge_irq_en_q;
    logic falling_edge_irq_en_q;
    logic [1:0] response_mode_sel_q;
    logic [2:0] sync_q;
    logic comparator_output_state_q;
    logic rise_evt;
    logic fall_evt;
    logic settled;
    logic wr_ctrl;
    logic wr_insel;
    logic wr_mode;
    logic [7:0] rdata_d;
    logic [7:0] pos_pin_d;
    logic [7:0] neg_pin_d;

    // Address decode for the three registers
    assign wr_ctrl = SFR_WR_IN && (SFR_ADDR_IN == `CMPR_ADDR_CTRL);
    assign wr_insel = SFR_WR_IN && (SFR_ADDR_IN == `CMPR_ADDR_INSEL);
    assign wr_mode = SFR_WR_IN && (SFR_ADDR_IN == `CMPR_ADDR_MODE);

    // Three-stage synchroniser; the first stage feeds only the second
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            sync_q <= 3'h0;
        end else begin
            sync_q <= {sync_q[1:0], CMP_RAW_IN};
        end
    end

    // A level counts only once stages two and three agree
    assign settled = (sync_q[1] == sync_q[2]);
    assign rise_evt = comparator_enable_bit_q && settled && sync_q[2]
        && !comparator_output_state_q;
    assign fall_evt = comparator_enable_bit_q && settled && !sync_q[2]
        && comparator_output_state_q;

    // Filtered comparator state, shown as the read-only output bit
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            comparator_output_state_q <= 1'b0;
        end else if (settled) begin
            comparator_output_state_q <= sync_q[2];
        end
    end

    // Sticky edge flags; a new edge beats a software clear in the same cycle
    always_comb begin
        rising_edge_flag_d = rising_edge_flag_q;
        falling_edge_flag_d = falling_edge_flag_q;
        if (wr_ctrl) begin
            rising_edge_flag_d = SFR_WDATA_IN[`CMPR_CTRL_RISE_BIT];
            falling_edge_flag_d = SFR_WDATA_IN[`CMPR_CTRL_FALL_BIT];
        end
        if (rise_evt) begin
            rising_edge_flag_d = 1'b1;
        end
        if (fall_evt) begin
            falling_edge_flag_d = 1'b1;
        end
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            rising_edge_flag_q <= 1'((`CMPR_RST_CTRL >> `CMPR_CTRL_RISE_BIT) & 8'h01);
            falling_edge_flag_q <= 1'((`CMPR_RST_CTRL >> `CMPR_CTRL_FALL_BIT) & 8'h01);
        end else begin
            rising_edge_flag_q <= rising_edge_flag_d;
            falling_edge_flag_q <= falling_edge_flag_d;
        end
    end

    // Control register: enable and hysteresis codes; output bit is not writable
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            comparator_enable_bit_q <= 1'((`CMPR_RST_CTRL >> `CMPR_CTRL_EN_BIT) & 8'h01);
            positive_hysteresis_sel_q <= 2'h0;
            negative_hysteresis_sel_q <= 2'h0;
        end else if (wr_ctrl) begin
            comparator_enable_bit_q <= SFR_WDATA_IN[`CMPR_CTRL_EN_BIT];
            positive_hysteresis_sel_q <=
                SFR_WDATA_IN[`CMPR_CTRL_HYP_MSB:`CMPR_CTRL_HYP_LSB];
            negative_hysteresis_sel_q <=
                SFR_WDATA_IN[`CMPR_CTRL_HYN_MSB:`CMPR_CTRL_HYN_LSB];
        end
    end

    // Input-select register; unused bits are simply not stored
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            negative_input_sel_q <= 3'h0;
            positive_input_sel_q <= 3'h0;
        end else if (wr_insel) begin
            negative_input_sel_q <=
                SFR_WDATA_IN[`CMPR_INSEL_NEG_MSB:`CMPR_INSEL_NEG_LSB];
            positive_input_sel_q <=
                SFR_WDATA_IN[`CMPR_INSEL_POS_MSB:`CMPR_INSEL_POS_LSB];
        end
    end

    // Mode register; reset leaves response mode 2
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            rising_edge_irq_en_q <= 1'b0;
            falling_edge_irq_en_q <= 1'b0;
            response_mode_sel_q <= 2'h2;
        end else if (wr_mode) begin
            rising_edge_irq_en_q <= SFR_WDATA_IN[`CMPR_MODE_RISE_EN_BIT];
            falling_edge_irq_en_q <= SFR_WDATA_IN[`CMPR_MODE_FALL_EN_BIT];
            response_mode_sel_q <=
                SFR_WDATA_IN[`CMPR_MODE_RESP_MSB:`CMPR_MODE_RESP_LSB];
        end
    end

    // Pin lookup; undefined codes park the mux on no pin at all
    always_comb begin
        pos_pin_d = `CMPR_PIN_NONE;
        neg_pin_d = `CMPR_PIN_NONE;
        if (positive_input_sel_q <= `CMPR_INSEL_LAST_CODE) begin
            pos_pin_d = PACKAGE_48PIN ? POS_MAP_48[positive_input_sel_q]
                : POS_MAP_32[positive_input_sel_q];
        end
        if (negative_input_sel_q <= `CMPR_INSEL_LAST_CODE) begin
            neg_pin_d = PACKAGE_48PIN ? NEG_MAP_48[negative_input_sel_q]
                : NEG_MAP_32[negative_input_sel_q];
        end
    end

    // Analog-side settings, registered so outputs come from flip-flops
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            CMP_ENABLE_OUT <= 1'b0;
            POS_HYST_OUT <= cmpr_pkg::CMPR_HYST_OFF;
            NEG_HYST_OUT <= cmpr_pkg::CMPR_HYST_OFF;
            POS_PIN_OUT <= 8'h00;
            NEG_PIN_OUT <= 8'h00;
            RESP_MODE_OUT <= cmpr_pkg::CMPR_RESP_MID2;
        end else begin
            CMP_ENABLE_OUT <= comparator_enable_bit_q;
            POS_HYST_OUT <= cmpr_pkg::cmpr_hyst_e'(positive_hysteresis_sel_q);
            NEG_HYST_OUT <= cmpr_pkg::cmpr_hyst_e'(negative_hysteresis_sel_q);
            POS_PIN_OUT <= pos_pin_d;
            NEG_PIN_OUT <= neg_pin_d;
            RESP_MODE_OUT <= cmpr_pkg::cmpr_resp_e'(response_mode_sel_q);
        end
    end

    // Interrupt requests follow flag and enable; a level, cleared with the flag
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            RISE_IRQ_OUT <= 1'b0;
            FALL_IRQ_OUT <= 1'b0;
        end else begin
            RISE_IRQ_OUT <= rising_edge_flag_q && rising_edge_irq_en_q;
            FALL_IRQ_OUT <= falling_edge_flag_q && falling_edge_irq_en_q;
        end
    end

    // Read mux; unused bits and unmapped addresses read zero
    always_comb begin
        rdata_d = 8'h00;
        if (!SFR_RD_IN) begin
            rdata_d = 8'h00;
        end else if (SFR_ADDR_IN == `CMPR_ADDR_CTRL) begin
            rdata_d = {comparator_enable_bit_q, comparator_output_state_q,
                rising_edge_flag_q, falling_edge_flag_q,
                positive_hysteresis_sel_q, negative_hysteresis_sel_q};
        end else if (SFR_ADDR_IN == `CMPR_ADDR_INSEL) begin
            rdata_d = {1'b0, negative_input_sel_q, 1'b0, positive_input_sel_q};
        end else if (SFR_ADDR_IN == `CMPR_ADDR_MODE) begin
            rdata_d = {2'b00, rising_edge_irq_en_q, falling_edge_irq_en_q,
                2'b00, response_mode_sel_q};
        end
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            SFR_RDATA_OUT <= 8'h00;
        end else begin
            SFR_RDATA_OUT <= rdata_d;
        end
    end

    chk_fall_flag_set: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        fall_evt |=> falling_edge_flag_q)
        else $error("Falling edge did not set its flag");

    chk_pos_hyst_out: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        wr_ctrl |=> ##1 (POS_HYST_OUT == $past(SFR_WDATA_IN[3:2], 2)))
        else $error("Positive hysteresis output does not follow write");

    chk_neg_hyst_out: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        wr_ctrl |=> ##1 (NEG_HYST_OUT == $past(SFR_WDATA_IN[1:0], 2)))
        else $error("Negative hysteresis output does not follow write");

    chk_neg_pin_none: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        (wr_insel && SFR_WDATA_IN[6:4] > 3'h4) |=> ##1 (NEG_PIN_OUT == 8'hFF))
        else $error("Undefined negative code did not park the mux");

    chk_pos_pin_map: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        (wr_insel && SFR_WDATA_IN[2:0] == 3'h4) |=> ##1
        (POS_PIN_OUT == (PACKAGE_48PIN ? 8'h11 : 8'h04)))
        else $error("Positive code four maps to the wrong pin");

    chk_insel_unused: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        (SFR_RD_IN && SFR_ADDR_IN == 8'h9E) |=> (SFR_RDATA_OUT[7] == 1'b0
        && SFR_RDATA_OUT[3] == 1'b0))
        else $error("Unused input-select bits read non-zero");

    chk_rise_irq_gate: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        !rising_edge_irq_en_q |=> !RISE_IRQ_OUT)
        else $error("Rising request while disabled");

    chk_fall_irq_gate: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        !falling_edge_irq_en_q |=> !FALL_IRQ_OUT)
        else $error("Falling request while disabled");

    chk_resp_mode_out: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        wr_mode |=> ##1 (RESP_MODE_OUT == $past(SFR_WDATA_IN[1:0], 2)))
        else $error("Response mode output does not follow write");

    chk_mode_unused: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        (SFR_RD_IN && SFR_ADDR_IN == 8'h9C) |=> (SFR_RDATA_OUT[7:6] == 2'b00))
        else $error("Unused mode bits read non-zero");

    chk_rise_flag_set: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        rise_evt |=> rising_edge_flag_q)
        else $error("Rising edge did not set its flag");

    chk_out_state_rd: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        (SFR_RD_IN && SFR_ADDR_IN == 8'h9A) |=>
        (SFR_RDATA_OUT[6] == $past(comparator_output_state_q)))
        else $error("Output state bit reads wrongly");

    chk_enable_out: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        wr_ctrl |=> ##1 (CMP_ENABLE_OUT == $past(SFR_WDATA_IN[7], 2)))
        else $error("Enable output does not follow write");

    chk_rise_irq_on: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        (rising_edge_flag_q && rising_edge_irq_en_q) |=> RISE_IRQ_OUT)
        else $error("Rising request missing");

endmodule

`default_nettype wire

//--- include/cmpr_cfg.svh
// Constants for the comparator control register bank.
// Assumes an 8-bit special-function register space with byte addresses.
`ifndef CMPR_CFG_SVH
`define CMPR_CFG_SVH

// Register addresses in the special-function space
`define CMPR_ADDR_CTRL 8'h9A
`define CMPR_ADDR_INSEL 8'h9E
`define CMPR_ADDR_MODE 8'h9C

// Reset values
`define CMPR_RST_CTRL 8'h00
`define CMPR_RST_INSEL 8'h00
`define CMPR_RST_MODE 8'h02

// Control register fields
`define CMPR_CTRL_EN_BIT 7
`define CMPR_CTRL_OUT_BIT 6
`define CMPR_CTRL_RISE_BIT 5
`define CMPR_CTRL_FALL_BIT 4
`define CMPR_CTRL_HYP_MSB 3
`define CMPR_CTRL_HYP_LSB 2
`define CMPR_CTRL_HYN_MSB 1
`define CMPR_CTRL_HYN_LSB 0

// Input-select register fields and writable mask
`define CMPR_INSEL_NEG_MSB 6
`define CMPR_INSEL_NEG_LSB 4
`define CMPR_INSEL_POS_MSB 2
`define CMPR_INSEL_POS_LSB 0
`define CMPR_INSEL_MASK 8'h77
`define CMPR_INSEL_LAST_CODE 3'h4

// Mode register fields and writable mask
`define CMPR_MODE_RISE_EN_BIT 5
`define CMPR_MODE_FALL_EN_BIT 4
`define CMPR_MODE_RESP_MSB 1
`define CMPR_MODE_RESP_LSB 0
`define CMPR_MODE_MASK 8'h33

// Pin code shown for an undefined select code
`define CMPR_PIN_NONE 8'hFF

`endif

//--- include/cmpr_pkg.sv
// Types shared by the comparator control register bank.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package cmpr_pkg;

    // Hysteresis setting handed to the analog comparator
    typedef enum logic [1:0] {
        CMPR_HYST_OFF = 2'b00,
        CMPR_HYST_5MV = 2'b01,
        CMPR_HYST_10MV = 2'b10,
        CMPR_HYST_20MV = 2'b11
    } cmpr_hyst_e;

    // Response-time mode, fastest to lowest power
    typedef enum logic [1:0] {
        CMPR_RESP_FAST = 2'b00,
        CMPR_RESP_MID1 = 2'b01,
        CMPR_RESP_MID2 = 2'b10,
        CMPR_RESP_LOWPWR = 2'b11
    } cmpr_resp_e;

endpackage

`default_nettype wire

//--- bench/testbench.sv
// Self-checking bench for the comparator control register bank.
// Assumes the design files, cmpr_pkg and cmpr_cfg.svh are compiled first.
`include "cmpr_cfg.svh"
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_in;
    logic reset_n_in;
    logic [7:0] sfr_addr;
    logic sfr_wr;
    logic sfr_rd;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic cmp_raw;
    logic cmp_enable;
    cmpr_pkg::cmpr_hyst_e pos_hyst;
    cmpr_pkg::cmpr_hyst_e neg_hyst;
    logic [7:0] pos_pin;
    logic [7:0] neg_pin;
    cmpr_pkg::cmpr_resp_e resp_mode;
    logic rise_irq;
    logic fall_irq;
    int fail_count;
    int n_tests;
    // Expected 32-pin map as {port, bit}; codes 5 to 7 select nothing
    logic [7:0] pos_tbl [8] = '{8'h12, 8'h16, 8'h22, 8'h26, 8'h04, 8'hFF, 8'hFF, 8'hFF};
    logic [7:0] neg_tbl [8] = '{8'h13, 8'h17, 8'h23, 8'h27, 8'h05, 8'hFF, 8'hFF, 8'hFF};

    cmpr_ctrl #(.PACKAGE_48PIN(1'b0)) u_dut (
        .CLK_IN(clk_in),
        .RESET_N_IN(reset_n_in),
        .SFR_ADDR_IN(sfr_addr),
        .SFR_WR_IN(sfr_wr),
        .SFR_RD_IN(sfr_rd),
        .SFR_WDATA_IN(sfr_wdata),
        .SFR_RDATA_OUT(sfr_rdata),
        .CMP_RAW_IN(cmp_raw),
        .CMP_ENABLE_OUT(cmp_enable),
        .POS_HYST_OUT(pos_hyst),
        .NEG_HYST_OUT(neg_hyst),
        .POS_PIN_OUT(pos_pin),
        .NEG_PIN_OUT(neg_pin),
        .RESP_MODE_OUT(resp_mode),
        .RISE_IRQ_OUT(rise_irq),
        .FALL_IRQ_OUT(fall_irq)
    );

    // 125 MHz system clock
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    // Compare one value; four-state compare so unknowns never match
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe, launched and dropped on rising edges
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_in);
        sfr_addr <= addr;
        sfr_wdata <= data;
        sfr_wr <= 1'b1;
        @(posedge clk_in);
        sfr_wr <= 1'b0;
    endtask

    // Read data is registered, so it is valid just after the sampling edge
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk_in);
        sfr_addr <= addr;
        sfr_rd <= 1'b1;
        @(posedge clk_in);
        sfr_rd <= 1'b0;
        #1;
        data = sfr_rdata;
    endtask

    // Outputs settle one edge after the write; two spare edges for margin
    task automatic settle(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic results();
        $display("Counts: %0d compares, %0d mismatches", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk_in);
        fail_count++;
        results();
    end

    initial begin
        logic [7:0] d;
        logic [7:0] v;
        reset_n_in = 1'b0;
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_wdata = 8'h00;
        cmp_raw = 1'b0;
        fail_count = 0;
        n_tests = 0;
        repeat (6) @(posedge clk_in);
        reset_n_in <= 1'b1;

        // Reset values, unmapped address
        rd(`CMPR_ADDR_CTRL, d); chk(d, 8'h00);
        rd(`CMPR_ADDR_INSEL, d); chk(d, 8'h00);
        rd(`CMPR_ADDR_MODE, d); chk(d, 8'h02);
        rd(8'h9B, d); chk(d, 8'h00);
        chk({6'h00, resp_mode}, 8'h02);
        chk({7'h00, cmp_enable}, 8'h00);
        chk(pos_pin, pos_tbl[0]);
        $display("test reset done");

        // Every select code on both fields, unused bits written as ones
        for (int i = 0; i < 8; i++) begin
            v = {1'b1, 3'(i), 1'b1, 3'(7 - i)};
            wr(`CMPR_ADDR_INSEL, v);
            settle(3);
            chk(neg_pin, neg_tbl[i]);
            chk(pos_pin, pos_tbl[7 - i]);
            rd(`CMPR_ADDR_INSEL, d); chk(d, v & 8'h77);
        end
        $display("test input select done");

        // All hysteresis codes, positive and negative opposite
        for (int i = 0; i < 4; i++) begin
            v = {4'h0, 2'(i), 2'(3 - i)};
            wr(`CMPR_ADDR_CTRL, v);
            settle(3);
            chk({6'h00, pos_hyst}, 8'(i));
            chk({6'h00, neg_hyst}, 8'(3 - i));
            rd(`CMPR_ADDR_CTRL, d); chk(d, v);
        end
        $display("test hysteresis done");

        // All response modes; unused mode bits written as ones
        for (int i = 0; i < 4; i++) begin
            wr(`CMPR_ADDR_MODE, 8'hCC | 8'(i));
            settle(3);
            chk({6'h00, resp_mode}, 8'(i));
            rd(`CMPR_ADDR_MODE, d); chk(d, 8'(i));
        end
        wr(`CMPR_ADDR_MODE, 8'hFF);
        rd(`CMPR_ADDR_MODE, d); chk(d, 8'h33);
        $display("test mode done");

        // Edge flags, output state and gated requests
        wr(`CMPR_ADDR_MODE, 8'h00);
        wr(`CMPR_ADDR_CTRL, 8'h80);
        settle(3);
        chk({7'h00, cmp_enable}, 8'h01);
        @(posedge clk_in);
        cmp_raw <= 1'b1;
        settle(8);
        rd(`CMPR_ADDR_CTRL, d); chk(d, 8'hE0);
        chk({7'h00, rise_irq}, 8'h00);
        wr(`CMPR_ADDR_MODE, 8'h20);
        settle(4);
        chk({7'h00, rise_irq}, 8'h01);
        wr(`CMPR_ADDR_CTRL, 8'h80);
        settle(3);
        rd(`CMPR_ADDR_CTRL, d); chk(d, 8'hC0);
        chk({7'h00, rise_irq}, 8'h00);
        @(posedge clk_in);
        cmp_raw <= 1'b0;
        settle(8);
        rd(`CMPR_ADDR_CTRL, d); chk(d, 8'h90);
        chk({7'h00, fall_irq}, 8'h00);
        wr(`CMPR_ADDR_MODE, 8'h10);
        settle(4);
        chk({7'h00, fall_irq}, 8'h01);
        wr(`CMPR_ADDR_CTRL, 8'h00);
        settle(3);
        chk({7'h00, cmp_enable}, 8'h00);
        chk({7'h00, fall_irq}, 8'h00);
        // Disabled comparator: a rise updates the state bit but sets no flag
        @(posedge clk_in);
        cmp_raw <= 1'b1;
        settle(8);
        rd(`CMPR_ADDR_CTRL, d); chk(d, 8'h40);
        $display("test edges done");
        results();
    end
endmodule

`default_nettype wire
